/* File: sfw_fifo.sv */
// sfw_fifo: small synchronous fifo with registered read data.
// assumes: single clock, asynchronous active-low reset.
`default_nettype none
module sfw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic flush_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be power of 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty = (wp_q == rp_q);
  assign do_wr = wr_valid_in && !full;
  assign do_rd = !empty && (!rd_valid_out || rd_ready_in);
  assign wr_ready_out = !full;
  always_ff @(posedge clk_sys_in) begin
    if (do_wr) begin
      mem_q[wp_q[AW-1:0]] <= wr_data_in;
    end
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wp_q <= '0;
      rp_q <= '0;
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
    end else if (flush_in) begin
      wp_q <= '0;
      rp_q <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      if (do_wr) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_rd) begin
        rp_q <= rp_q + 1'b1;
        rd_data_out <= mem_q[rp_q[AW-1:0]];
        rd_valid_out <= 1'b1;
      end else if (rd_ready_in) begin
        rd_valid_out <= 1'b0;
      end
    end
  end
endmodule : sfw_fifo
`default_nettype wire

/* File: sfw_host.sv */
// sfw_host: behavioural serial flash controller on the link pins.
// assumes: the bench calls its tasks one frame at a time.
`default_nettype none
module sfw_host (
  output var logic sclk_out,
  output var logic cs_n_out,
  output var logic [3:0] data_line_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    data_line_out = 4'hA;
  end
  // lines change while clock is low, device samples on the rise
  task automatic edge4(input logic [3:0] v);
    data_line_out = v;
    #(HALF) sclk_out = 1'b1;
    #(HALF) sclk_out = 1'b0;
  endtask : edge4
  task automatic sel();
    cs_n_out = 1'b0;
    #(HALF);
  endtask : sel
  // unused lines keep toggling so they never look held
  task automatic bit1(input logic b);
    edge4({~data_line_out[3:1], b});
  endtask : bit1
  task automatic byte1(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bit1(b[i]);
    end
  endtask : byte1
  task automatic quad1(input logic [7:0] b);
    edge4(b[7:4]);
    edge4(b[3:0]);
  endtask : quad1
  task automatic addr(input logic [31:0] a, input logic wide,
                      input logic quad);
    for (int i = 3; i >= 0; i--) begin
      if (wide || i < 3) begin
        if (quad) begin
          quad1(a[i*8 +: 8]);
        end else begin
          byte1(a[i*8 +: 8]);
        end
      end
    end
  endtask : addr
  task automatic desel();
    #(HALF);
    cs_n_out = 1'b1;
    data_line_out = ~data_line_out;
    #(4 * HALF);
  endtask : desel
endmodule : sfw_host
`default_nettype wire

/* File: sfw_pkg.sv */
// sfw_pkg: shared constants for the flash command sequencer.
// assumes: included before sfw_fifo.sv and sfw_seq.sv.
`default_nettype none
package sfw_pkg;
  localparam logic [7:0] OP_WRAP = 8'h77;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_FOUR_BYTE_ENABLE_BIT = 8'hB7;
  localparam logic [7:0] OP_EX4B = 8'hE9;
  localparam int WRAP_DUMMY_BITS = 24;
  localparam int WRAP_BITS = 8;
  localparam int WRAP_DIS_POS = 4;
  localparam int WRAP_LEN_LO = 5;
  localparam logic [2:0] WRAP_RESET = 3'h7;
  localparam int PAGE_BITS = 8;
  localparam int SECTOR_BITS = 12;
  localparam int BLK32_BITS = 15;
  localparam int ADDR3_BITS = 24;
  localparam int ADDR4_BITS = 32;
  localparam int CLK_MHZ = 250;
  localparam int PROG_TIME_US = 600;
  localparam int ERASE_TIME_US = 45000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int WEL_CLR_DIV = 2;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPCODE = 6'h02,
    ST_ADDR = 6'h04,
    ST_DATA = 6'h08,
    ST_SKIP = 6'h10,
    ST_BUSY = 6'h20
  } sfw_state_type;
endpackage : sfw_pkg
`default_nettype wire

/* File: sfw_seq.sv */
// sfw_seq: command sequencer for wrap setup, page program and erase.
// assumes: serial clock and chip select come from pins and are
// synchronised here; the array sits outside behind the program stream
// and the erase request ports.
`default_nettype none
module sfw_seq
  import sfw_pkg::*;
#(
  parameter int PROG_CNT = PROG_CYCLES,
  parameter int ERASE_CNT = ERASE_CYCLES,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic data_line_0_in,
  input wire logic data_line_1_in,
  input wire logic data_line_2_in,
  input wire logic data_line_3_in,
  input wire logic four_byte_enable_bit_in,
  input wire logic [4:0] block_protect_in,
  input wire logic [ADDR4_BITS-1:0] protect_lo_in,
  input wire logic [ADDR4_BITS-1:0] protect_hi_in,
  output logic write_in_progress_out,
  output logic write_enable_latch_out,
  output logic four_byte_mode_out,
  output logic wrap_enable_out,
  output logic [1:0] wrap_length_field_out,
  output logic prog_valid_out,
  input wire logic prog_ready_in,
  output logic [ADDR4_BITS-1:0] prog_addr_out,
  output logic [7:0] prog_data_out,
  output logic erase_req_out,
  output logic erase_block_out,
  output logic [ADDR4_BITS-1:0] erase_addr_out
);
  initial begin
    if (PROG_CNT < WEL_CLR_DIV || ERASE_CNT < WEL_CLR_DIV)
      $error("cycle counts too small");
  end

  function automatic logic is_protected(input logic [ADDR4_BITS-1:0] a,
      input logic [4:0] bp, input logic [ADDR4_BITS-1:0] lo,
      input logic [ADDR4_BITS-1:0] hi);
    is_protected = (bp != 5'h00) && (a >= lo) && (a <= hi);
  endfunction : is_protected

  // two-flop synchronisers
  logic [1:0] sclk_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] d0_s_q;
  logic [1:0] d1_s_q;
  logic [1:0] d2_s_q;
  logic [1:0] d3_s_q;
  logic sclk_prev_q;
  logic cs_prev_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      d0_s_q <= 2'h0;
      d1_s_q <= 2'h0;
      d2_s_q <= 2'h0;
      d3_s_q <= 2'h0;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk_in};
      cs_s_q <= {cs_s_q[0], cs_n_in};
      d0_s_q <= {d0_s_q[0], data_line_0_in};
      d1_s_q <= {d1_s_q[0], data_line_1_in};
      d2_s_q <= {d2_s_q[0], data_line_2_in};
      d3_s_q <= {d3_s_q[0], data_line_3_in};
      sclk_prev_q <= sclk_s_q[1];
      cs_prev_q <= cs_s_q[1];
    end
  end
  logic rise;
  logic cs_rise;
  logic sel;
  assign sel = !cs_s_q[1];
  assign rise = sel && sclk_s_q[1] && !sclk_prev_q;
  assign cs_rise = cs_s_q[1] && !cs_prev_q;

  sfw_state_type state_q;
  logic [7:0] op_q;
  logic [7:0] sh_q;
  logic [5:0] bits_q;
  logic quad_q;
  logic [ADDR4_BITS-1:0] addr_q;
  logic [8:0] nbytes_q;
  logic four_byte_enable_bit_q;
  logic busy_erase_q;
  logic [31:0] timer_q;
  logic frame_ok_q;
  logic [ADDR4_BITS-1:0] tgt_q;

  // one bit per edge; quad data path takes four a time
  logic [7:0] sh_next;
  logic [5:0] bits_next;
  logic [5:0] addr_len;
  logic is_prog;
  logic is_erase;
  always_comb begin
    sh_next = quad_q ? {sh_q[3:0], d3_s_q[1], d2_s_q[1], d1_s_q[1],
      d0_s_q[1]} : {sh_q[6:0], d0_s_q[1]};
    bits_next = bits_q + (quad_q ? 6'h04 : 6'h01);
    addr_len = (four_byte_enable_bit_q || four_byte_enable_bit_in) ?
      6'(ADDR4_BITS) : 6'(ADDR3_BITS);
    is_prog = (op_q == OP_PAGE_PROG) || (op_q == OP_QUAD_PROG);
    is_erase = (op_q == OP_SECT_ERASE) || (op_q == OP_BLK32_ERASE);
  end

  logic [ADDR4_BITS-1:0] addr_next;
  assign addr_next = (addr_len == 6'(ADDR4_BITS)) ?
    {addr_q[ADDR4_BITS-9:0], sh_next} :
    {8'h00, addr_q[ADDR3_BITS-9:0], sh_next};

  // data byte stream into fifo
  logic byte_push;
  logic [7:0] byte_val;
  logic fifo_wr_ready;
  logic fifo_flush;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [7:0] fifo_rd_data;
  logic drain_q;
  logic [7:0] page_off_q;
  logic [7:0] drop_q;
  logic drop_now;
  logic fifo_pop;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      op_q <= 8'h00;
      sh_q <= 8'h00;
      bits_q <= 6'h00;
      quad_q <= 1'b0;
      addr_q <= '0;
      nbytes_q <= 9'h000;
      frame_ok_q <= 1'b0;
      byte_push <= 1'b0;
      byte_val <= 8'h00;
    end else begin
      byte_push <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (sel) begin
            state_q <= ST_OPCODE;
            bits_q <= 6'h00;
            quad_q <= 1'b0;
            nbytes_q <= 9'h000;
            frame_ok_q <= 1'b0;
            addr_q <= '0;
          end
        end
        ST_OPCODE: begin
          if (!sel) begin
            state_q <= ST_IDLE;
          end else if (rise) begin
            sh_q <= sh_next;
            if (bits_next == 6'h08) begin
              op_q <= sh_next;
              bits_q <= 6'h00;
              quad_q <= (sh_next == OP_QUAD_PROG);
              if (sh_next == OP_WRAP) begin
                state_q <= ST_ADDR;
              end else if ((sh_next == OP_PAGE_PROG ||
                  sh_next == OP_QUAD_PROG || sh_next == OP_SECT_ERASE ||
                  sh_next == OP_BLK32_ERASE) && write_in_progress_out) begin
                state_q <= ST_SKIP;
              end else if (sh_next == OP_PAGE_PROG ||
                  sh_next == OP_QUAD_PROG || sh_next == OP_SECT_ERASE ||
                  sh_next == OP_BLK32_ERASE) begin
                state_q <= ST_ADDR;
              end else begin
                frame_ok_q <= 1'b1;
                state_q <= ST_SKIP;
              end
            end else begin
              bits_q <= bits_next;
            end
          end
        end
        ST_ADDR: begin
          if (!sel) begin
            state_q <= ST_IDLE;
          end else if (rise) begin
            sh_q <= sh_next;
            bits_q <= bits_next;
            if (bits_next[2:0] == 3'h0) begin
              addr_q <= addr_next;
            end
            if (op_q == OP_WRAP && bits_next ==
                6'(WRAP_DUMMY_BITS + WRAP_BITS)) begin
              frame_ok_q <= 1'b1;
              state_q <= ST_SKIP;
            end else if (op_q != OP_WRAP && bits_next == addr_len) begin
              bits_q <= 6'h00;
              frame_ok_q <= is_erase;
              state_q <= is_erase ? ST_SKIP : ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (!sel) begin
            state_q <= ST_IDLE;
          end else if (rise) begin
            sh_q <= sh_next;
            frame_ok_q <= 1'b0;
            if (bits_next == 6'h08) begin
              bits_q <= 6'h00;
              byte_push <= 1'b1;
              byte_val <= sh_next;
              frame_ok_q <= 1'b1;
              if (nbytes_q != 9'h100) begin
                nbytes_q <= nbytes_q + 9'h001;
              end
            end else begin
              bits_q <= bits_next;
            end
          end
        end
        ST_SKIP: begin
          if (!sel) begin
            state_q <= ST_IDLE;
          end else if (rise) begin
            frame_ok_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // command execution at deselect
  logic go_prog;
  logic go_erase;
  logic go_wrap;
  assign go_prog = cs_rise && frame_ok_q && is_prog && state_q == ST_DATA;
  assign go_erase = cs_rise && frame_ok_q && is_erase && state_q == ST_SKIP;
  assign go_wrap = cs_rise && frame_ok_q && op_q == OP_WRAP;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wrap_enable_out <= 1'b0;
      wrap_length_field_out <= 2'h0;
    end else if (go_wrap) begin
      wrap_enable_out <= !sh_q[WRAP_DIS_POS];
      wrap_length_field_out <= sh_q[WRAP_LEN_LO +: 2];
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      four_byte_enable_bit_q <= 1'b0;
      four_byte_mode_out <= 1'b0;
    end else begin
      if (frame_ok_q && cs_rise && op_q == OP_FOUR_BYTE_ENABLE_BIT) begin
        four_byte_enable_bit_q <= 1'b1;
      end else if (frame_ok_q && cs_rise && op_q == OP_EX4B) begin
        four_byte_enable_bit_q <= 1'b0;
      end
      four_byte_mode_out <= four_byte_enable_bit_q || four_byte_enable_bit_in;
    end
  end

  // busy cycle, latch and fifo draining
  logic accept_prog;
  logic accept_erase;
  assign accept_prog = go_prog && write_enable_latch_out && nbytes_q != 0 &&
    !write_in_progress_out &&
    !is_protected(addr_q, block_protect_in, protect_lo_in,
      protect_hi_in);
  assign accept_erase = go_erase && write_enable_latch_out &&
    !write_in_progress_out &&
    !is_protected(addr_q, block_protect_in, protect_lo_in,
      protect_hi_in);
  assign fifo_flush = (state_q == ST_IDLE && sel && !drain_q) ||
    (go_prog && !accept_prog);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      write_in_progress_out <= 1'b0;
      write_enable_latch_out <= 1'b0;
      busy_erase_q <= 1'b0;
      timer_q <= '0;
      drain_q <= 1'b0;
    end else begin
      if (accept_prog || accept_erase) begin
        write_in_progress_out <= 1'b1;
        busy_erase_q <= accept_erase;
        timer_q <= accept_erase ? 32'(ERASE_CNT) : 32'(PROG_CNT);
        drain_q <= accept_prog;
      end else if (write_in_progress_out) begin
        if (timer_q == 32'h1) begin
          write_in_progress_out <= 1'b0;
          drain_q <= 1'b0;
        end else begin
          timer_q <= timer_q - 32'h1;
        end
        if (!fifo_rd_valid) begin
          drain_q <= 1'b0;
        end
      end
      if (cs_rise && frame_ok_q && op_q == OP_WRITE_ENABLE_CMD &&
          !write_in_progress_out) begin
        write_enable_latch_out <= 1'b1;
      end else if (write_in_progress_out &&
          timer_q == 32'(WEL_CLR_DIV)) begin
        write_enable_latch_out <= 1'b0;
      end
    end
  end

  // start offset kept; last FIFO_DEPTH bytes map from wrap of pointer
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tgt_q <= '0;
      page_off_q <= 8'h00;
      drop_q <= 8'h00;
      prog_valid_out <= 1'b0;
      prog_addr_out <= '0;
      prog_data_out <= 8'h00;
      erase_req_out <= 1'b0;
      erase_block_out <= 1'b0;
      erase_addr_out <= '0;
    end else begin
      erase_req_out <= accept_erase;
      if (accept_erase) begin
        erase_block_out <= (op_q == OP_BLK32_ERASE);
        erase_addr_out <= (op_q == OP_BLK32_ERASE) ?
          {addr_q[ADDR4_BITS-1:BLK32_BITS], {BLK32_BITS{1'b0}}} :
          {addr_q[ADDR4_BITS-1:SECTOR_BITS],
          {SECTOR_BITS{1'b0}}};
      end
      if (fifo_flush) begin
        drop_q <= 8'h00;
      end else if (drop_now) begin
        drop_q <= drop_q + 8'h01;
      end
      if (accept_prog) begin
        tgt_q <= addr_q;
        page_off_q <= addr_q[PAGE_BITS-1:0] + drop_q;
      end
      if (prog_valid_out && prog_ready_in) begin
        prog_valid_out <= 1'b0;
      end
      if (fifo_rd_ready) begin
        prog_valid_out <= 1'b1;
        prog_addr_out <= {tgt_q[ADDR4_BITS-1:PAGE_BITS], page_off_q};
        prog_data_out <= fifo_rd_data;
        page_off_q <= page_off_q + 8'h01;
      end
    end
  end
  assign fifo_rd_ready = drain_q && fifo_rd_valid &&
    (!prog_valid_out || prog_ready_in);

  // fifo holds newest bytes; oldest dropped when full
  assign drop_now = state_q == ST_DATA && sel && !fifo_wr_ready &&
    fifo_rd_valid;
  assign fifo_pop = fifo_rd_ready || drop_now;

  sfw_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .flush_in(fifo_flush),
    .wr_valid_in(byte_push && fifo_wr_ready),
    .wr_ready_out(fifo_wr_ready),
    .wr_data_in(byte_val),
    .rd_valid_out(fifo_rd_valid),
    .rd_ready_in(fifo_pop),
    .rd_data_out(fifo_rd_data)
  );
endmodule : sfw_seq
`default_nettype wire

/* File: sfw_seq_bench.sv */
// sfw_seq_bench: self-checking bench for the flash command sequencer.
// assumes: sfw_host drives the link, the bench plays the array side.
`default_nettype none
module sfw_seq_bench
  import sfw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PCNT = 400;
  localparam int ECNT = 3000;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic four_in = 1'b0;
  logic rdy = 1'b1;
  logic [4:0] bp = 5'h00;
  logic [31:0] hi = 32'h0;
  logic sclk, cs_n, write_in_progress, write_enable_latch, fbm, wen, pv, ereq, eblk, e_blk_q;
  logic wide = 1'b0;
  logic [3:0] dl;
  logic [1:0] wlen;
  logic [7:0] pdata;
  logic [31:0] paddr, eaddr, e_addr_q;
  logic [31:0] qa[$];
  logic [7:0] qd[$];
  int n_fail = 0;
  int n_checks = 0;
  int n_erase = 0;
  always #2 clk_sys = ~clk_sys;
  sfw_host host (.sclk_out(sclk), .cs_n_out(cs_n), .data_line_out(dl));
  sfw_seq #(.PROG_CNT(PCNT), .ERASE_CNT(ECNT), .FIFO_DEPTH(32)) dut (
    .clk_sys_in(clk_sys), .reset_n_in(reset_n), .sclk_in(sclk),
    .cs_n_in(cs_n), .data_line_0_in(dl[0]), .data_line_1_in(dl[1]),
    .data_line_2_in(dl[2]), .data_line_3_in(dl[3]),
    .four_byte_enable_bit_in(four_in), .block_protect_in(bp),
    .protect_lo_in(32'h0), .protect_hi_in(hi),
    .write_in_progress_out(write_in_progress), .write_enable_latch_out(write_enable_latch),
    .four_byte_mode_out(fbm), .wrap_enable_out(wen),
    .wrap_length_field_out(wlen), .prog_valid_out(pv),
    .prog_ready_in(rdy), .prog_addr_out(paddr), .prog_data_out(pdata),
    .erase_req_out(ereq), .erase_block_out(eblk), .erase_addr_out(eaddr));
  // array side: collect program beats and erase requests
  always @(posedge clk_sys) begin
    if (pv === 1'b1 && rdy === 1'b1) begin
      qa.push_back(paddr);
      qd.push_back(pdata);
    end
    if (ereq === 1'b1) begin
      n_erase++;
      e_addr_q = eaddr;
      e_blk_q = eblk;
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic end_test(input string name);
    $display("test %s over, mismatches %0d", name, n_fail);
  endtask : end_test
  task automatic settle();
    repeat (16) @(posedge clk_sys);
  endtask : settle
  task automatic wait_idle();
    for (int i = 0; i < 20000 && write_in_progress !== 1'b0; i++) begin
      @(posedge clk_sys);
    end
    settle();
  endtask : wait_idle
  task automatic cmd1(input logic [7:0] op);
    host.sel();
    host.byte1(op);
    host.desel();
    settle();
  endtask : cmd1
  task automatic wrap_cmd(input logic [7:0] b);
    host.sel();
    host.byte1(OP_WRAP);
    repeat (3) host.byte1(8'h00);
    host.byte1(b);
    host.desel();
    settle();
  endtask : wrap_cmd
  task automatic erase(input logic [7:0] op, input logic [31:0] a,
                       input int nbad);
    cmd1(OP_WRITE_ENABLE_CMD);
    host.sel();
    host.byte1(op);
    host.addr(a, wide, 1'b0);
    repeat (nbad) host.bit1(1'b1);
    host.desel();
    settle();
  endtask : erase
  task automatic prog(input logic [7:0] op, input logic [31:0] a,
                      input int n, input int nbad, input logic wr);
    if (wr) begin
      cmd1(OP_WRITE_ENABLE_CMD);
    end
    host.sel();
    host.byte1(op);
    host.addr(a, wide, op == OP_QUAD_PROG);
    for (int i = 0; i < n; i++) begin
      if (op == OP_QUAD_PROG) begin
        host.quad1(8'hA0 + 8'(i));
      end else begin
        host.byte1(8'hA0 + 8'(i));
      end
    end
    repeat (nbad) host.bit1(1'b1);
    host.desel();
    settle();
  endtask : prog
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(32'(write_in_progress), 32'h0);
    check(32'(write_enable_latch), 32'h0);
    check(32'(wen), 32'h0);
    end_test("reset");
    for (int i = 0; i < 4; i++) begin
      wrap_cmd({1'b0, 2'(i), 1'b0, 4'h0});
      check(32'(wen), 32'h1);
      check(32'(wlen), 32'(i));
    end
    wrap_cmd(8'h70);
    check(32'(wen), 32'h0);
    end_test("wrap");
    prog(OP_PAGE_PROG, 32'h100, 1, 0, 1'b0);
    check(32'(write_in_progress), 32'h0);
    check(32'(qa.size()), 32'h0);
    rdy <= 1'b0;
    prog(OP_PAGE_PROG, 32'hFE, 34, 0, 1'b1);
    check(32'(write_in_progress), 32'h1);
    repeat (20) @(posedge clk_sys);
    rdy <= 1'b1;
    wait_idle();
    repeat (64) @(posedge clk_sys);
    check(32'(qa.size()), 32'h20);
    check(qa[0], 32'h0);
    check(qa[2], 32'h2);
    check(32'(qd[2]), 32'hA4);
    check(32'(write_enable_latch), 32'h0);
    qa.delete();
    qd.delete();
    prog(OP_PAGE_PROG, 32'h200, 1, 3, 1'b1);
    check(32'(write_in_progress), 32'h0);
    check(32'(qa.size()), 32'h0);
    end_test("program");
    for (int k = 0; k < 2; k++) begin
      erase(k ? OP_BLK32_ERASE : OP_SECT_ERASE, 32'h12345, 0);
      check(32'(n_erase), 32'(k + 1));
      check(e_addr_q, k ? 32'h10000 : 32'h12000);
      check(32'(e_blk_q), 32'(k));
      check(32'(write_in_progress), 32'h1);
      if (k == 1) begin
        erase(OP_SECT_ERASE, 32'h2000, 0);
      end
      wait_idle();
    end
    check(32'(n_erase), 32'h2);
    erase(OP_SECT_ERASE, 32'h3000, 1);
    check(32'(n_erase), 32'h2);
    bp <= 5'h01;
    hi <= 32'hFFFFFFFF;
    erase(OP_SECT_ERASE, 32'h3000, 0);
    prog(OP_PAGE_PROG, 32'h300, 1, 0, 1'b0);
    check(32'(n_erase), 32'h2);
    check(32'(qa.size()), 32'h0);
    bp <= 5'h00;
    end_test("erase");
    four_in <= 1'b1;
    wide = 1'b1;
    erase(OP_SECT_ERASE, 32'h01012345, 0);
    check(e_addr_q, 32'h01012000);
    wait_idle();
    four_in <= 1'b0;
    cmd1(OP_FOUR_BYTE_ENABLE_BIT);
    check(32'(fbm), 32'h1);
    erase(OP_BLK32_ERASE, 32'h02019000, 0);
    check(e_addr_q, 32'h02018000);
    wait_idle();
    cmd1(OP_EX4B);
    wide = 1'b0;
    check(32'(fbm), 32'h0);
    end_test("four byte");
    prog(OP_QUAD_PROG, 32'h210, 2, 0, 1'b1);
    wait_idle();
    check(qa[0], 32'h210);
    check(32'(qd[0]), 32'hA0);
    check(qa[1], 32'h211);
    check(32'(qd[1]), 32'hA1);
    end_test("quad");
    complete_run();
  end
endmodule : sfw_seq_bench
`default_nettype wire

/* File: sfw_seq_properties.sv */
// sfw_seq_properties: port-level checks for the flash command sequencer.
// assumes: bound to every sfw_seq instance, single clock domain.
`default_nettype none
module sfw_seq_properties #(
  parameter int PROG_CNT = 64,
  parameter int ERASE_CNT = 64
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic write_in_progress_out,
  input wire logic write_enable_latch_out,
  input wire logic wrap_enable_out,
  input wire logic [1:0] wrap_length_field_out,
  input wire logic prog_valid_out,
  input wire logic prog_ready_in,
  input wire logic [31:0] prog_addr_out,
  input wire logic [7:0] prog_data_out,
  input wire logic erase_req_out,
  input wire logic erase_block_out,
  input wire logic [31:0] erase_addr_out
);
  localparam int MIN_CNT = (PROG_CNT < ERASE_CNT) ? PROG_CNT : ERASE_CNT;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // length of the current busy stretch
  int busy_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_q <= 0;
    end else begin
      busy_q <= write_in_progress_out ? busy_q + 1 : 0;
    end
  end
  sequence s_quiet_link;
    cs_n_in && $past(cs_n_in, 2);
  endsequence
  sequence s_pulse_end;
    ##1 !erase_req_out;
  endsequence
  sequence s_busy_soon;
    ##[0:8] write_in_progress_out;
  endsequence
  chk_erase_single_pulse: assert property (
    erase_req_out |-> s_pulse_end) else $error("erase request too long");
  chk_erase_sets_busy: assert property (
    erase_req_out |-> s_busy_soon) else $error("erase without busy flag");
  chk_erase_at_deselect: assert property (
    erase_req_out |-> s_quiet_link) else $error("erase while selected");
  chk_sector_aligned: assert property (
    erase_req_out && !erase_block_out |-> erase_addr_out[11:0] == 12'h000)
    else $error("sector erase base not aligned");
  chk_block_aligned: assert property (
    erase_req_out && erase_block_out |-> erase_addr_out[14:0] == 15'h0000)
    else $error("block erase base not aligned");
  chk_cycle_needs_latch: assert property (
    $rose(write_in_progress_out) |-> $past(write_enable_latch_out))
    else $error("timed cycle without latch");
  chk_latch_cleared: assert property (
    $fell(write_in_progress_out) |-> !write_enable_latch_out)
    else $error("latch still set after cycle");
  chk_busy_full_time: assert property (
    $fell(write_in_progress_out) |-> busy_q >= MIN_CNT - 2)
    else $error("timed cycle too short");
  chk_prog_held: assert property (
    prog_valid_out && !prog_ready_in |=> prog_valid_out &&
    $stable(prog_addr_out) && $stable(prog_data_out))
    else $error("program beat changed while stalled");
  chk_wrap_at_deselect: assert property (
    !$stable({wrap_enable_out, wrap_length_field_out}) |-> s_quiet_link)
    else $error("wrap setting changed mid frame");
endmodule : sfw_seq_properties
bind sfw_seq sfw_seq_properties #(
  .PROG_CNT(PROG_CNT), .ERASE_CNT(ERASE_CNT)
) u_props (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n_in),
  .write_in_progress_out(write_in_progress_out),
  .write_enable_latch_out(write_enable_latch_out),
  .wrap_enable_out(wrap_enable_out),
  .wrap_length_field_out(wrap_length_field_out),
  .prog_valid_out(prog_valid_out), .prog_ready_in(prog_ready_in),
  .prog_addr_out(prog_addr_out), .prog_data_out(prog_data_out),
  .erase_req_out(erase_req_out), .erase_block_out(erase_block_out),
  .erase_addr_out(erase_addr_out)
);
`default_nettype wire
